// ### shared/cbtaf_cfg.svh
// What this block does
// R1: bit = sync, segment one, segment two
// R2: bit length 4 to 25 quanta
// R3: sample after segment one, launch after two
// R4: each segment length set by four-bit field
// R5: software keeps jump limit within both segments
// R6: sync segment is always one quantum
// R7: idle falling edge restarts bit timing
// R8: phase error signed by segment of edge
// R9: small phase error acts as hard sync
// R10: large negative error shortens segment two
// R11: large positive error lengthens segment one
// R12: resync only on falling edges while receiving
// R13: prescaler divides core clock into quanta
// R14: bit rate = clock / (div*(1+seg1+seg2))
// R15: fifteen buffers of eight 16-bit words
// R16: frame stored in first matching buffer only
// R17: status write schedules buffer for sending
// R18: remote frame schedules every matching answerer
// R19: shared mask 0-13, catch-all mask 14
// R20: mask bit one makes id bit don't-care
// R21: scan 0 to 13 before buffer 14
// R22: lock after one frame until rearmed
// R23: locked buffers skipped, discard if none
// R24: staged frame copied only at validation
// R25: software arms buffer with code 0010
// R26: one resync per bit, none while transmitting
`ifndef CBTAF_CFG_SVH
`define CBTAF_CFG_SVH
// register byte addresses
`define CBTAF_OFS_TIMING 12'h000
`define CBTAF_OFS_CONFIG 12'h004
`define CBTAF_OFS_SMASK 12'h008
`define CBTAF_OFS_CMASK 12'h00C
`define CBTAF_OFS_STATUS 12'h010
`define CBTAF_OFS_RAM 12'h400
// timing register fields
`define CBTAF_DIV_LSB 0
`define CBTAF_SEG1_LSB 8
`define CBTAF_SEG2_LSB 12
`define CBTAF_SJW_LSB 16
// reset values: divider 1, seg1 5, seg2 4, jump 1 (10 quanta)
`define CBTAF_RST_DIV 8'h01
`define CBTAF_RST_SEG1 4'h5
`define CBTAF_RST_SEG2 4'h4
`define CBTAF_RST_SJW 2'h0
`define CBTAF_MIN_BIT 5'h04
`define CBTAF_MAX_BIT 5'h19
`define CBTAF_IDLE_BITS 4'hB
// buffer status codes
`define CBTAF_RX_NOT_ACTIVE 4'h0
`define CBTAF_RX_READY 4'h2
`define CBTAF_RX_FULL 4'h4
`define CBTAF_RX_OVERRUN 4'h5
`define CBTAF_TX_NOT_ACTIVE 4'h8
`define CBTAF_TX_RTR_ANSWER 4'hA
`define CBTAF_TX_ONCE 4'hC
`endif

// ### shared/cbtaf_pkg.sv
package cbtaf_pkg;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cbtaf_apb_req_t;
  // contents of the hidden staging buffer
  typedef struct packed {
    logic [31:0] id;
    logic remote;
    logic [3:0] dlc;
    logic [63:0] data;
  } cbtaf_frame_t;
  // bit segment, one-hot
  typedef enum logic [2:0] {
    CBTAF_SYNC = 3'b001,
    CBTAF_SEG1 = 3'b010,
    CBTAF_SEG2 = 3'b100
  } cbtaf_seg_t;
endpackage

// ### core/cbtaf_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbtaf_cfg.svh"
module cbtaf_core
  import cbtaf_pkg::*;
#(
  parameter int NBUF = 15
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire cbtaf_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // can bus side
  input wire logic can_rx,
  input wire logic tx_dominant,
  output logic sample_pt,
  output logic bit_value,
  output logic tx_pt,
  output logic bus_idle,
  // frame engine side
  input wire logic stage_load,
  input wire cbtaf_frame_t stage_frame,
  input wire logic frame_validated,
  input wire logic tx_done,
  input wire logic [3:0] tx_done_buf,
  output logic [14:0] tx_pending
);
  // the store is fixed at fifteen buffers by the mask split
  if (NBUF != 15)
  begin : g_nbuf_bad
    $error("cbtaf_core serves exactly fifteen buffers");
  end
  // all state of the block
  typedef struct packed {
    logic [14:0][7:0][15:0] ram; // message buffers
    logic [7:0] div; // quantum divider
    logic [3:0] seg1; // phase before sample
    logic [3:0] seg2; // phase after sample
    logic [1:0] resync_jump_limit; // jump limit minus one
    logic lock; // lock on receive
    logic [31:0] smask; // shared accept mask
    logic [31:0] cmask; // catchall accept mask
    logic [14:0] pend; // transmit schedule
    logic [3:0] last_buf; // last receiving buffer
    logic discard; // last frame taken by none
    cbtaf_frame_t stage; // hidden staging buffer
    logic [7:0] quantum_divider; // prescaler count
    cbtaf_seg_t seg; // current segment
    logic [4:0] q; // quantum within segment
    logic [2:0] ext; // segment one lengthening
    logic [2:0] shr; // segment two shortening
    logic resynced; // resync done this bit
    logic prev_rx; // bus level at last quantum
    logic [3:0] idle_cnt; // recessive bits seen
    logic idle; // bus idle
    logic sample_pt; // sample pulse
    logic bit_value; // sampled bit
    logic tx_pt; // launch pulse
    logic [31:0] prdata; // read answer
    logic pready; // access done
    logic pslverr; // unmapped access
  } cbtaf_state_t;
  cbtaf_state_t st_r;
  cbtaf_state_t st_nxt;
  // per buffer acceptance result
  logic [14:0] rx_hit;
  logic [14:0] rtr_hit;
  // acceptance filter, one lane per buffer
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi = gi + 1)
    begin : g_filt
      logic [31:0] bid;
      logic [31:0] msk;
      logic [3:0] code;
      logic idok;
      logic locked;
      assign bid = {st_r.ram[gi][0], st_r.ram[gi][1]};
      // buffer 14 has its own mask
      assign msk = (gi == 14) ? st_r.cmask : st_r.smask; // R19
      assign code = st_r.ram[gi][7][3:0];
      // set mask bits are don't-care
      assign idok = ((bid ^ st_r.stage.id) & ~msk) == 32'h0000_0000; // R20
      // a full buffer holds its frame while locking is on
      assign locked = st_r.lock && ((code == `CBTAF_RX_FULL) ||
                                    (code == `CBTAF_RX_OVERRUN)); // R22
      assign rx_hit[gi] = idok && !locked && ((code == `CBTAF_RX_READY) ||
                          (code == `CBTAF_RX_FULL) ||
                          (code == `CBTAF_RX_OVERRUN)); // R23
      assign rtr_hit[gi] = idok && (code == `CBTAF_TX_RTR_ANSWER); // R18
    end
  endgenerate
  // next state
  always_comb
  begin
    logic [7:0] divv;
    logic [4:0] tot;
    logic [4:0] sj;
    logic [4:0] e;
    logic fall;
    logic tick;
    logic found;
    logic [3:0] sel;
    logic acc;
    logic [3:0] bi;
    logic [2:0] wi;
    logic [3:0] cur;
    divv = 8'h00;
    tot = 5'h00;
    sj = 5'h00;
    e = 5'h00;
    fall = 1'b0;
    tick = 1'b0;
    found = 1'b0;
    sel = 4'h0;
    acc = 1'b0;
    bi = 4'h0;
    wi = 3'h0;
    cur = 4'h0;
    st_nxt = st_r;
    st_nxt.sample_pt = 1'b0;
    st_nxt.tx_pt = 1'b0;
    // prescaler; a zero divider acts as one
    divv = (st_r.div == 8'h00) ? 8'h01 : st_r.div;
    if (st_r.quantum_divider >= divv - 8'h01) // R13
    begin
      tick = 1'b1;
      st_nxt.quantum_divider = 8'h00;
    end
    else
    begin
      st_nxt.quantum_divider = st_r.quantum_divider + 8'h01;
    end
    sj = {3'b000, st_r.resync_jump_limit} + 5'h01;
    // bit timing, one step per quantum
    if (tick)
    begin
      fall = st_r.prev_rx && !can_rx;
      st_nxt.prev_rx = can_rx;
      if (fall && st_r.idle)
      begin
        // start of frame: edge quantum is the sync segment
        st_nxt.seg = CBTAF_SEG1; // R7
        st_nxt.q = 5'h00;
        st_nxt.ext = 3'h0;
        st_nxt.shr = 3'h0;
        st_nxt.resynced = 1'b1;
        st_nxt.idle = 1'b0;
        st_nxt.idle_cnt = 4'h0;
      end
      else if (fall && !st_r.idle && !st_r.resynced && !tx_dominant) // R12 R26
      begin
        st_nxt.resynced = 1'b1; // R26
        case (st_r.seg)
          CBTAF_SEG1:
          begin
            // late edge, positive error
            e = st_r.q + 5'h01; // R8
            if (e <= sj)
            begin
              st_nxt.seg = CBTAF_SEG1; // R9
              st_nxt.q = 5'h00;
            end
            else
            begin
              st_nxt.ext = st_r.resync_jump_limit + 3'h1; // R11
              st_nxt.q = st_r.q + 5'h01;
            end
          end
          CBTAF_SEG2:
          begin
            // early edge, negative error of the remaining quanta
            e = {1'b0, st_r.seg2} - st_r.q; // R8
            if (e <= sj)
            begin
              st_nxt.seg = CBTAF_SEG1; // R9
              st_nxt.q = 5'h00;
              st_nxt.shr = 3'h0;
              st_nxt.ext = 3'h0;
            end
            else
            begin
              // shortened segment ends at once when already past
              st_nxt.shr = st_r.resync_jump_limit + 3'h1; // R10
              st_nxt.q = st_r.q + 5'h01;
            end
          end
          default:
          begin
            // edge in the sync segment: zero error
            st_nxt.seg = CBTAF_SEG1; // R8
            st_nxt.q = 5'h00;
          end
        endcase
      end
      else
      begin
        case (st_r.seg)
          CBTAF_SYNC:
          begin
            // sync is one quantum whatever the setting
            st_nxt.seg = CBTAF_SEG1; // R6
            st_nxt.q = 5'h00;
          end
          CBTAF_SEG1:
          begin
            if (st_r.q + 5'h01 >= {1'b0, st_r.seg1} + {2'b00, st_r.ext}) // R1
            begin
              // sample point between the segments
              st_nxt.sample_pt = 1'b1; // R3
              st_nxt.bit_value = can_rx;
              st_nxt.seg = CBTAF_SEG2;
              st_nxt.q = 5'h00;
              if (!can_rx)
              begin
                st_nxt.idle_cnt = 4'h0;
                st_nxt.idle = 1'b0;
              end
              else if (st_r.idle_cnt + 4'h1 >= `CBTAF_IDLE_BITS)
              begin
                st_nxt.idle = 1'b1;
                st_nxt.idle_cnt = `CBTAF_IDLE_BITS;
              end
              else
              begin
                st_nxt.idle_cnt = st_r.idle_cnt + 4'h1;
              end
            end
            else
            begin
              st_nxt.q = st_r.q + 5'h01;
            end
          end
          CBTAF_SEG2:
          begin
            if (st_r.q + 5'h01 + {2'b00, st_r.shr} >= {1'b0, st_r.seg2}) // R14
            begin
              // launch point closes the bit
              st_nxt.tx_pt = 1'b1; // R3
              st_nxt.seg = CBTAF_SYNC;
              st_nxt.q = 5'h00;
              st_nxt.ext = 3'h0;
              st_nxt.shr = 3'h0;
              st_nxt.resynced = 1'b0;
            end
            else
            begin
              st_nxt.q = st_r.q + 5'h01;
            end
          end
          default:
          begin
            st_nxt.seg = CBTAF_SYNC;
            st_nxt.q = 5'h00;
          end
        endcase
      end
    end
    // staging buffer is invisible to software
    if (stage_load)
      st_nxt.stage = stage_frame; // R24
    // transmit done clears its schedule bit
    if (tx_done && (tx_done_buf < 4'hF))
      st_nxt.pend[tx_done_buf] = 1'b0;
    // apb access, one wait state
    st_nxt.pready = apb_req.psel && apb_req.penable && !st_r.pready;
    acc = apb_req.psel && apb_req.penable && st_r.pready;
    bi = apb_req.paddr[8:5];
    wi = apb_req.paddr[4:2];
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (apb_req.psel && apb_req.penable && !st_r.pready)
    begin
      // read answer prepared in the first access cycle
      case (apb_req.paddr)
        `CBTAF_OFS_TIMING: st_nxt.prdata = {14'h0000, st_r.resync_jump_limit, st_r.seg2,
                                            st_r.seg1, st_r.div};
        `CBTAF_OFS_CONFIG: st_nxt.prdata = {31'h0000_0000, st_r.lock};
        `CBTAF_OFS_SMASK: st_nxt.prdata = st_r.smask;
        `CBTAF_OFS_CMASK: st_nxt.prdata = st_r.cmask;
        `CBTAF_OFS_STATUS: st_nxt.prdata = {10'h000, st_r.discard, st_r.last_buf,
                                            st_r.idle, 1'b0, st_r.pend};
        default:
        begin
          if ((apb_req.paddr[11:9] == 3'b010) && (bi < 4'hF))
            st_nxt.prdata = {16'h0000, st_r.ram[bi][wi]};
          else
            st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (acc && apb_req.pwrite && !st_r.pslverr)
    begin
      case (apb_req.paddr)
        `CBTAF_OFS_TIMING:
        begin
          tot = 5'h01 + {1'b0, apb_req.pwdata[11:8]} + {1'b0, apb_req.pwdata[15:12]};
          // lengths outside the legal bit are refused
          if ((tot >= `CBTAF_MIN_BIT) && (tot <= `CBTAF_MAX_BIT) &&
              (apb_req.pwdata[11:8] != 4'h0) && (apb_req.pwdata[15:12] != 4'h0)) // R2
          begin
            st_nxt.div = apb_req.pwdata[`CBTAF_DIV_LSB +: 8];
            st_nxt.seg1 = apb_req.pwdata[`CBTAF_SEG1_LSB +: 4]; // R4
            st_nxt.seg2 = apb_req.pwdata[`CBTAF_SEG2_LSB +: 4]; // R4
            st_nxt.resync_jump_limit = apb_req.pwdata[`CBTAF_SJW_LSB +: 2]; // R5
          end
        end
        `CBTAF_OFS_CONFIG: st_nxt.lock = apb_req.pwdata[0];
        `CBTAF_OFS_SMASK: st_nxt.smask = apb_req.pwdata;
        `CBTAF_OFS_CMASK: st_nxt.cmask = apb_req.pwdata;
        `CBTAF_OFS_STATUS: st_nxt.discard = st_r.discard;
        default:
        begin
          st_nxt.ram[bi][wi] = apb_req.pwdata[15:0]; // R15
          // a send code in the status word schedules the buffer
          if ((wi == 3'h7) && (apb_req.pwdata[3:0] == `CBTAF_TX_ONCE))
            st_nxt.pend[bi] = 1'b1; // R17
        end
      endcase
    end
    // copy the staged frame at validation
    if (frame_validated) // R24
    begin
      // first hit in ascending order, 14 last
      for (int k = 0; k < 15; k++)
      begin
        if (rx_hit[k] && !found) // R16 R21
        begin
          found = 1'b1;
          sel = k[3:0];
        end
      end
      if (found)
      begin
        cur = st_r.ram[sel][7][3:0];
        st_nxt.ram[sel][0] = st_r.stage.id[31:16];
        st_nxt.ram[sel][1] = st_r.stage.id[15:0];
        st_nxt.ram[sel][2] = st_r.stage.data[63:48];
        st_nxt.ram[sel][3] = st_r.stage.data[47:32];
        st_nxt.ram[sel][4] = st_r.stage.data[31:16];
        st_nxt.ram[sel][5] = st_r.stage.data[15:0];
        st_nxt.ram[sel][6] = {11'h000, st_r.stage.remote, st_r.stage.dlc};
        // hardware status update wins over a same-cycle write
        st_nxt.ram[sel][7][3:0] = (cur == `CBTAF_RX_READY) ? `CBTAF_RX_FULL :
                                  `CBTAF_RX_OVERRUN; // R22
        st_nxt.last_buf = sel;
      end
      st_nxt.discard = !found; // R23
      if (st_r.stage.remote)
        st_nxt.pend = st_nxt.pend | rtr_hit; // R18
    end
  end
  // state register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.div <= `CBTAF_RST_DIV;
      st_r.seg1 <= `CBTAF_RST_SEG1;
      st_r.seg2 <= `CBTAF_RST_SEG2;
      st_r.resync_jump_limit <= `CBTAF_RST_SJW;
      st_r.seg <= CBTAF_SYNC;
      st_r.prev_rx <= 1'b1;
      st_r.bit_value <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  // outputs straight from the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign sample_pt = st_r.sample_pt;
  assign bit_value = st_r.bit_value;
  assign tx_pt = st_r.tx_pt;
  assign bus_idle = st_r.idle;
  assign tx_pending = st_r.pend;
endmodule
`default_nettype wire

// ### verif/cbtaf_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cbtaf_core_asserts
  import cbtaf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire cbtaf_apb_req_t apb_req,
  input wire logic pready,
  input wire logic pslverr,
  // bit timing
  input wire logic sample_pt,
  input wire logic bit_value,
  input wire logic tx_pt,
  input wire logic bus_idle,
  // frame engine
  input wire logic frame_validated,
  input wire logic tx_done,
  input wire logic [3:0] tx_done_buf,
  input wire logic [14:0] tx_pending
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  AST_APB_ONE_WAIT:
    assert property (apb_req.psel && !apb_req.penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  AST_PREADY_PULSE:
    assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_SLVERR_WITH_READY:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_SAMPLE_PULSE:
    assert property (sample_pt |=> !sample_pt)
    else $error("sample point wider than one cycle");
  AST_POINTS_APART:
    assert property (tx_pt |-> !sample_pt)
    else $error("sample and launch points coincide");
  AST_SYNC_FIRST:
    assert property (tx_pt |=> !sample_pt)
    else $error("sample point right after launch");
  AST_IDLE_RECESSIVE:
    assert property (bus_idle |-> bit_value)
    else $error("idle with dominant bit");
  AST_DOMINANT_ENDS_IDLE:
    assert property (sample_pt ##1 !bit_value |-> !bus_idle)
    else $error("idle kept after dominant sample");
  AST_DONE_CLEARS:
    assert property (tx_done && tx_done_buf < 4'hF && !pready && !frame_validated
      |=> !tx_pending[$past(tx_done_buf)])
    else $error("finished buffer still pending");
  AST_NO_STRAY_PENDING:
    assert property (!pready && !frame_validated
      |=> (tx_pending & ~$past(tx_pending)) == 15'h0000)
    else $error("pending set without a cause");
endmodule
bind cbtaf_core cbtaf_core_asserts i_cbtaf_core_asserts (.clk, .sys_rst, .apb_req, .pready,
  .pslverr, .sample_pt, .bit_value, .tx_pt, .bus_idle, .frame_validated, .tx_done,
  .tx_done_buf, .tx_pending);
`default_nettype wire

// ### verif/cbtaf_node.sv
`timescale 1ns/1ps
`default_nettype none
module cbtaf_node
(
  // shared clock of the bench
  input wire logic clk,
  // bus level, recessive high
  output logic can_rx
);
  // pull-up keeps the bus recessive outside frames
  initial can_rx = 1'b1;
  // msb first, each bit held cpb clocks; own rate may differ from ours
  task automatic send(input logic [15:0] bits, input int cpb);
    for (int i = 15; i >= 0; i--)
      repeat (cpb) @(posedge clk) can_rx <= bits[i];
    @(posedge clk) can_rx <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### verif/can_bit_timing_and_acceptance_filter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbtaf_cfg.svh"
module can_bit_timing_and_acceptance_filter_tb
  import cbtaf_pkg::*;
;
  // stimulus
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  cbtaf_apb_req_t req = '0;
  logic tx_dominant = 1'b0;
  logic stage_load = 1'b0;
  cbtaf_frame_t frame = '0;
  logic frame_validated = 1'b0;
  logic tx_done = 1'b0;
  logic [3:0] tx_done_buf = 4'h0;
  // observed
  logic can_rx, sample_pt, bit_value, tx_pt, bus_idle, pready, pslverr, last_err;
  logic [31:0] prdata, rd;
  logic [14:0] tx_pending;
  logic [15:0] got;
  int fail_count = 0;
  int samples_checked = 0;
  int n, i;
  always #25 clk = ~clk;
  cbtaf_core i_cbtaf_core (.clk, .sys_rst, .apb_req(req), .prdata, .pready, .pslverr,
    .can_rx, .tx_dominant, .sample_pt, .bit_value, .tx_pt, .bus_idle, .stage_load,
    .stage_frame(frame), .frame_validated, .tx_done, .tx_done_buf, .tx_pending);
  cbtaf_node i_cbtaf_node (.clk, .can_rx);
  // verdict, the only exit
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    last_err = pslverr;
    req <= '0;
    if (pready !== 1'b1)
    begin
      chk("apb answer", 32'h0, 32'h1);
      stop_test();
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  function automatic logic [11:0] ram(input int b, input int w);
    return 12'(`CBTAF_OFS_RAM + b * 32 + w * 4);
  endfunction
  // id in words 0 and 1, status code in word 7
  task automatic set_buf(input int b, input logic [31:0] id, input logic [3:0] st);
    apb(1'b1, ram(b, 0), {16'h0000, id[31:16]});
    apb(1'b1, ram(b, 1), {16'h0000, id[15:0]});
    apb(1'b1, ram(b, 7), {28'h0000000, st});
  endtask
  // load the staging buffer, validate one cycle later
  task automatic rx_frame(input logic [31:0] id, input logic rem);
    @(posedge clk);
    frame <= '{id, rem, 4'h8, 64'hA5A5_0001_0002_0003};
    stage_load <= 1'b1;
    @(posedge clk);
    stage_load <= 1'b0;
    frame_validated <= 1'b1;
    @(posedge clk);
    frame_validated <= 1'b0;
  endtask
  // bounded wait for a launch or sample pulse, n counts clocks
  task automatic wait_pt(input logic use_tx);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((use_tx ? tx_pt : sample_pt) !== 1'b1 && n < 1000);
    if (n >= 1000)
    begin
      chk("bit pulse", 32'h0, 32'h1);
      stop_test();
    end
  endtask
  // slow node puts a late edge deep in segment one of the third bit
  task automatic stretch(input logic dom, input logic [31:0] exp);
    tx_dominant <= dom;
    repeat (500) @(posedge clk);
    fork
      i_cbtaf_node.send(16'h5FFF, 17);
    join_none
    i = 0;
    do
    begin
      wait_pt(1'b0);
      i++;
    end
    while (bit_value !== 1'b0 && i < 50);
    wait_pt(1'b0);
    wait_pt(1'b0);
    chk("stretched bit", 32'(n), exp);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(`CBTAF_OFS_TIMING, 32'h0000_4501, "timing reset");
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", {31'h0, last_err}, 32'h0000_0001);
    // 31 quanta is too long, then 25 is the longest taken
    apb(1'b1, `CBTAF_OFS_TIMING, 32'h0000_FF01);
    rchk(`CBTAF_OFS_TIMING, 32'h0000_4501, "timing refused");
    apb(1'b1, `CBTAF_OFS_TIMING, 32'h0000_9F01);
    rchk(`CBTAF_OFS_TIMING, 32'h0000_9F01, "timing max");
    // divider 2, segments 3 and 2, jump limit 2 fits both segments
    apb(1'b1, `CBTAF_OFS_TIMING, 32'h0001_2302);
    wait_pt(1'b1);
    wait_pt(1'b1);
    chk("bit period", 32'(n), 32'h0000_000C);
    // eleven recessive bits take 132 clocks
    repeat (200) @(posedge clk);
    chk("idle", {31'h0, bus_idle}, 32'h0000_0001);
    // slower far node: resync must keep every bit
    fork
      i_cbtaf_node.send(16'h64D2, 13);
    join_none
    i = 0;
    do
    begin
      wait_pt(1'b0);
      @(posedge clk);
      i++;
    end
    while (bit_value !== 1'b0 && i < 50);
    chk("idle after start", {31'h0, bus_idle}, 32'h0);
    got = 16'h0000;
    for (i = 14; i >= 0; i--)
    begin
      wait_pt(1'b0);
      @(posedge clk);
      got[i] = bit_value;
    end
    chk("received bits", {16'h0000, got}, 32'h0000_64D2);
    // low byte of the id is a don't-care for buffers 0 to 13
    apb(1'b1, `CBTAF_OFS_SMASK, 32'h0000_00FF);
    set_buf(0, 32'h1234_0000, `CBTAF_RX_READY);
    set_buf(1, 32'h1234_0000, `CBTAF_RX_READY);
    set_buf(14, 32'h1234_0000, `CBTAF_RX_READY);
    rx_frame(32'h1234_00AB, 1'b0);
    rchk(ram(0, 7), 32'h4, "buf0 full");
    rchk(ram(0, 1), 32'h00AB, "buf0 id");
    rchk(ram(0, 2), 32'hA5A5, "buf0 data");
    rchk(ram(1, 7), 32'h2, "buf1 untouched");
    rchk(ram(14, 7), 32'h2, "buf14 exact");
    apb(1'b1, `CBTAF_OFS_CONFIG, 32'h1);
    rx_frame(32'h1234_0000, 1'b0);
    rchk(ram(1, 7), 32'h4, "buf1 next");
    rchk(ram(0, 7), 32'h4, "buf0 locked");
    rchk(ram(14, 7), 32'h2, "buf14 skipped");
    rx_frame(32'h1234_0000, 1'b0);
    rchk(ram(14, 7), 32'h4, "buf14 last");
    apb(1'b0, `CBTAF_OFS_STATUS, 32'h0);
    chk("last buffer", rd & 32'h003E_0000, 32'h001C_0000);
    rx_frame(32'h1234_0000, 1'b0);
    apb(1'b0, `CBTAF_OFS_STATUS, 32'h0);
    chk("discarded", rd & 32'h0020_0000, 32'h0020_0000);
    apb(1'b1, ram(0, 7), 32'h2);
    rx_frame(32'h1234_0011, 1'b0);
    rchk(ram(0, 1), 32'h0011, "rearmed");
    // software send and its completion
    apb(1'b1, ram(5, 7), 32'hC);
    @(posedge clk);
    chk("send once", {17'h0, tx_pending}, 32'h0000_0020);
    tx_done <= 1'b1;
    tx_done_buf <= 4'h5;
    @(posedge clk);
    tx_done <= 1'b0;
    @(posedge clk);
    chk("send done", {17'h0, tx_pending}, 32'h0);
    // one remote request wakes both answering buffers
    set_buf(6, 32'h0AAA_0000, `CBTAF_TX_RTR_ANSWER);
    set_buf(7, 32'h0AAA_0000, `CBTAF_TX_RTR_ANSWER);
    rx_frame(32'h0AAA_0055, 1'b1);
    @(posedge clk);
    chk("remote answers", {17'h0, tx_pending}, 32'h0000_00C0);
    // divider 1, segments 8 and 4, jump limit 2: 13 clocks a bit
    apb(1'b1, `CBTAF_OFS_TIMING, 32'h0001_4801);
    stretch(1'b1, 32'h0000_000D);
    stretch(1'b0, 32'h0000_000F);
    stop_test();
  end
endmodule
`default_nettype wire
